// >>> src/stream_cipher_pkg.sv
// Purpose: shared constants for the stream cipher unit and its controller
// Assumes: 12-bit word index addressing on the link
// Notes: offsets are word indices
package stream_cipher_pkg;
    localparam int ADDR_W = 12;
    localparam int DATA_W = 32;
    localparam logic [11:0] OFF_CONTROL = 12'h400;
    localparam logic [11:0] OFF_STATUS = 12'h401;
    localparam logic [11:0] OFF_BYTE_COUNT = 12'h408;
    localparam logic [11:0] OFF_KEY_LEN = 12'h409;
    localparam logic [11:0] OFF_KEY_LOW = 12'h40A;
    localparam logic [11:0] OFF_MESSAGE = 12'h40E;
    localparam logic [11:0] OFF_OUTPUT = 12'h40F;
    localparam logic [11:0] OFF_POINTERS = 12'h410;
    localparam logic [11:0] OFF_SBOX_BASE = 12'h440;
    localparam logic [5:0] SBOX_WORDS_M1 = 6'h3F;
    localparam logic [2:0] BC_DEFAULT = 3'h3;
    localparam int BC_LAST_BIT = 2;
    localparam int CTL_SOFT_RESET_BIT = 1;
    localparam int ST_IBE = 6;
    localparam int ST_FULL_DONE = 5;
    localparam int ST_SUB_DONE = 4;
    localparam int ST_PERM_DONE = 3;
    localparam int ST_INIT_DONE = 2;
    localparam int ST_BUSY = 0;
    localparam logic [7:0] BYTE_LAST = 8'hFF;
    // controller register indices
    localparam logic [3:0] HOFF_TARGET = 4'h0;
    localparam logic [3:0] HOFF_WRITE = 4'h1;
    localparam logic [3:0] HOFF_READ = 4'h2;
    localparam logic [3:0] HOFF_RESULT = 4'h3;
    localparam logic [3:0] HOFF_STATUS = 4'h4;
    localparam int HST_DONE = 0;
    localparam int HST_REFUSED = 1;
    localparam int HST_PTR_SAVED = 2;
    localparam int HST_SBOX_SAVED = 3;
    localparam int HST_PTR_RESTORED = 4;
    localparam int HST_SBOX_RESTORED = 5;
endpackage

// >>> src/stream_cipher_link.sv
// Purpose: register link between controller and cipher unit
// Assumes: one clock, read data one cycle after the read strobe
// Notes: none
`timescale 1ns/1ps
interface stream_cipher_link;
    logic [11:0] addr;
    logic [31:0] wdata;
    logic wr;
    logic rd;
    logic [31:0] rdata;
    modport device (input addr, input wdata, input wr, input rd, output rdata);
    modport host (output addr, output wdata, output wr, output rd, input rdata);
endinterface

// >>> src/stream_cipher_unit.sv
// Purpose: byte stream cipher engine with host-visible key, message, context registers
// Assumes: link strobes are one cycle, synchronous to sys_clk
// Notes: state memory is 64 words of four bytes, byte 0 in bits 7:0
`timescale 1ns/1ps
// Contract
// RULE_01 - key length: 4-bit write-only, bytes minus one
// RULE_02 - key length write starts state permutation
// RULE_03 - host writes key before key length
// RULE_04 - four 32-bit write-only key words, low first
// RULE_05 - host fills lower key words first
// RULE_06 - 3-bit byte count, last flag, count minus one
// RULE_07 - default sub-message length is four bytes
// RULE_08 - last sub-message: reinitialize, keep output
// RULE_09 - message write starts sub-message processing
// RULE_10 - output valid once done bit set
// RULE_11 - unused output bits copy message input
// RULE_12 - 24-bit pointer register, read/write when idle
// RULE_13 - host saves and restores pointers around switch
// RULE_14 - 64-word state memory, read/write when idle
// RULE_15 - host saves and restores whole state memory
// RULE_16 - input empty bit, cleared by message write
// RULE_17 - full done held until key; read clears
// RULE_18 - sub done set, cleared by next message
// RULE_19 - busy whenever core not idle
// RULE_20 - standard key schedule, XOR keystream bytes
// RULE_21 - four state bytes packed per word
// RULE_22 - key, message, context writes ignored while busy
module stream_cipher_unit
    import stream_cipher_pkg::*;
(
    input wire logic sys_clk,
    input wire logic srst,
    stream_cipher_link.device link
);
    typedef enum logic [1:0] {S_INIT, S_IDLE, S_PERM, S_MSG} state_e;

    state_e state;
    logic [31:0] mem [64];
    logic [7:0] i_ptr;
    logic [7:0] j_ptr;
    logic [7:0] k_idx;
    logic [3:0] key_len;
    logic [31:0] key [4];
    logic [2:0] byte_count;
    logic [1:0] byte_idx;
    logic [31:0] msg_out;
    logic ibe;
    logic full_done;
    logic sub_done;
    logic perm_done;
    logic init_done;
    logic soft_reset;
    logic [31:0] rdata;

    function automatic logic [7:0] sbyte(input logic [7:0] a);
        logic [31:0] w;
        w = mem[a[7:2]];
        return w[{a[1:0], 3'h0} +: 8];
    endfunction

    logic wr_idle;
    logic rst_all;
    logic [7:0] kbyte;
    logic [11:0] key_off;
    logic [1:0] key_sel;
    logic [7:0] perm_j;
    logic [7:0] msg_i;
    logic [7:0] si;
    logic [7:0] msg_j;
    logic [7:0] sj;
    logic [7:0] t_idx;
    logic [7:0] ks;
    logic [4:0] out_pos;
    logic [7:0] in_byte;
    logic last_byte;

    always_comb begin
        wr_idle = link.wr && (state == S_IDLE); // [RULE_22]
        rst_all = srst || soft_reset;
        kbyte = key[k_idx[3:2]][{k_idx[1:0], 3'h0} +: 8]; // [RULE_04]
        key_off = link.addr - OFF_KEY_LOW;
        key_sel = key_off[1:0];
        perm_j = j_ptr + sbyte(i_ptr) + kbyte; // [RULE_20]
        msg_i = i_ptr + 8'h01;
        si = sbyte(msg_i);
        msg_j = j_ptr + si;
        sj = sbyte(msg_j);
        t_idx = si + sj;
        if (t_idx == msg_i) begin
            ks = sj;
        end else if (t_idx == msg_j) begin
            ks = si;
        end else begin
            ks = sbyte(t_idx);
        end
        // most significant byte is processed first
        out_pos = {2'h3 - byte_idx, 3'h0};
        in_byte = msg_out[out_pos +: 8];
        last_byte = (byte_idx == byte_count[1:0]); // [RULE_06]
    end

    // engine sequencing and pointers
    always_ff @(posedge sys_clk) begin
        if (rst_all) begin
            state <= S_INIT;
            i_ptr <= 8'h00;
            j_ptr <= 8'h00;
            k_idx <= 8'h00;
            byte_idx <= 2'h0;
        end else begin
            case (state)
                S_INIT: begin
                    i_ptr <= i_ptr + 8'h04;
                    if (i_ptr[7:2] == SBOX_WORDS_M1) begin
                        state <= S_IDLE;
                        i_ptr <= 8'h00;
                    end
                end
                S_IDLE: begin
                    if (wr_idle && link.addr == OFF_KEY_LEN) begin
                        state <= S_PERM; // [RULE_02]
                        i_ptr <= 8'h00;
                        j_ptr <= 8'h00;
                        k_idx <= 8'h00;
                    end else if (wr_idle && link.addr == OFF_MESSAGE) begin
                        state <= S_MSG; // [RULE_09]
                        byte_idx <= 2'h0;
                    end else if (wr_idle && link.addr == OFF_POINTERS) begin
                        i_ptr <= link.wdata[15:8]; // [RULE_12]
                        j_ptr <= link.wdata[7:0];
                    end
                end
                S_PERM: begin
                    j_ptr <= perm_j;
                    i_ptr <= i_ptr + 8'h01;
                    k_idx <= (k_idx[3:0] == key_len) ? 8'h00 : k_idx + 8'h01; // [RULE_01]
                    if (i_ptr == BYTE_LAST) begin
                        state <= S_IDLE;
                        i_ptr <= 8'h00;
                        j_ptr <= 8'h00;
                    end
                end
                S_MSG: begin
                    i_ptr <= msg_i;
                    j_ptr <= msg_j;
                    byte_idx <= byte_idx + 2'h1;
                    if (last_byte) begin
                        state <= byte_count[BC_LAST_BIT] ? S_INIT : S_IDLE; // [RULE_08]
                        if (byte_count[BC_LAST_BIT]) begin
                            i_ptr <= 8'h00;
                            j_ptr <= 8'h00;
                        end
                    end
                end
                default: state <= S_INIT;
            endcase
        end
    end

    // state memory: fill, swaps, host context writes
    always_ff @(posedge sys_clk) begin
        if (state == S_INIT) begin
            mem[i_ptr[7:2]] <= {i_ptr + 8'h03, i_ptr + 8'h02, i_ptr + 8'h01, i_ptr}; // [RULE_21]
        end else if (state == S_PERM) begin
            mem[i_ptr[7:2]][{i_ptr[1:0], 3'h0} +: 8] <= sbyte(perm_j); // [RULE_20]
            mem[perm_j[7:2]][{perm_j[1:0], 3'h0} +: 8] <= sbyte(i_ptr);
        end else if (state == S_MSG) begin
            mem[msg_i[7:2]][{msg_i[1:0], 3'h0} +: 8] <= sj;
            mem[msg_j[7:2]][{msg_j[1:0], 3'h0} +: 8] <= si;
        end else if (wr_idle && link.addr[11:6] == OFF_SBOX_BASE[11:6]) begin
            mem[link.addr[5:0]] <= link.wdata; // [RULE_14]
        end
    end

    // key and sub-message length registers
    always_ff @(posedge sys_clk) begin
        if (rst_all) begin
            key_len <= 4'h0;
            byte_count <= BC_DEFAULT; // [RULE_07]
            for (int n = 0; n < 4; n++) begin
                key[n] <= 32'h0000_0000;
            end
        end else begin
            if (wr_idle && link.addr == OFF_KEY_LEN) begin
                key_len <= link.wdata[3:0]; // [RULE_01]
            end
            if (wr_idle && link.addr >= OFF_KEY_LOW && link.addr <= OFF_KEY_LOW + 12'h003) begin
                key[key_sel] <= link.wdata; // [RULE_04]
            end
            if (wr_idle && link.addr == OFF_BYTE_COUNT) begin
                byte_count <= link.wdata[2:0]; // [RULE_06]
            end else if (state == S_MSG && last_byte && byte_count[BC_LAST_BIT]) begin
                byte_count <= BC_DEFAULT; // [RULE_08]
            end
        end
    end

    // output word: starts as the input, bytes replaced as processed
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            msg_out <= 32'h0000_0000;
        end else if (wr_idle && link.addr == OFF_MESSAGE) begin
            msg_out <= link.wdata; // [RULE_11]
        end else if (state == S_MSG) begin
            msg_out[out_pos +: 8] <= in_byte ^ ks; // [RULE_20]
        end
    end

    // status flags, set wins over clear
    always_ff @(posedge sys_clk) begin
        if (rst_all) begin
            ibe <= 1'b1;
            full_done <= 1'b0;
            sub_done <= 1'b0;
            perm_done <= 1'b0;
            init_done <= 1'b0;
        end else begin
            if (state == S_MSG && last_byte) begin
                ibe <= 1'b1;
            end else if (wr_idle && link.addr == OFF_MESSAGE) begin
                ibe <= 1'b0; // [RULE_16]
            end
            if (state == S_MSG && last_byte && byte_count[BC_LAST_BIT]) begin
                full_done <= 1'b1;
            end else if ((link.rd && link.addr == OFF_OUTPUT)
                         || (wr_idle && link.addr == OFF_KEY_LEN)) begin
                full_done <= 1'b0; // [RULE_17]
            end
            if (state == S_MSG && last_byte) begin
                sub_done <= 1'b1; // [RULE_18]
            end else if (wr_idle && link.addr == OFF_MESSAGE) begin
                sub_done <= 1'b0;
            end
            if (state == S_PERM && i_ptr == BYTE_LAST) begin
                perm_done <= 1'b1;
            end else if (wr_idle && link.addr == OFF_MESSAGE) begin
                perm_done <= 1'b0;
            end
            if (state == S_INIT && i_ptr[7:2] == SBOX_WORDS_M1) begin
                init_done <= 1'b1;
            end else if (wr_idle && link.addr == OFF_KEY_LEN) begin
                init_done <= 1'b0;
            end
        end
    end

    // self-clearing software reset
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            soft_reset <= 1'b0;
        end else begin
            soft_reset <= link.wr && link.addr == OFF_CONTROL && link.wdata[CTL_SOFT_RESET_BIT];
        end
    end

    // read data, one cycle after the strobe
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            rdata <= 32'h0000_0000;
        end else if (link.rd) begin
            rdata <= 32'h0000_0000;
            if (link.addr == OFF_STATUS) begin
                rdata[ST_IBE] <= ibe;
                rdata[ST_FULL_DONE] <= full_done;
                rdata[ST_SUB_DONE] <= sub_done;
                rdata[ST_PERM_DONE] <= perm_done;
                rdata[ST_INIT_DONE] <= init_done;
                rdata[ST_BUSY] <= (state != S_IDLE); // [RULE_19]
            end else if (link.addr == OFF_OUTPUT) begin
                rdata <= msg_out; // [RULE_10]
            end else if (state == S_IDLE && link.addr == OFF_POINTERS) begin
                rdata <= {8'h00, i_ptr, j_ptr}; // [RULE_12]
            end else if (state == S_IDLE && link.addr[11:6] == OFF_SBOX_BASE[11:6]) begin
                rdata <= mem[link.addr[5:0]]; // [RULE_14]
            end
        end
    end

    assign link.rdata = rdata;
endmodule

// >>> src/stream_cipher_host.sv
// Purpose: controller that drives the cipher unit link on software orders
// Assumes: software port strobes are one cycle, never both at once
// Notes: refuses out-of-order key writes, tracks context save and restore
`timescale 1ns/1ps
module stream_cipher_host
    import stream_cipher_pkg::*;
(
    input wire logic sys_clk,
    input wire logic srst,
    input wire logic [3:0] sw_addr,
    input wire logic [31:0] sw_wdata,
    input wire logic sw_wr,
    input wire logic sw_rd,
    output logic [31:0] sw_rdata,
    stream_cipher_link.host link
);
    logic [11:0] target;
    logic [11:0] l_addr;
    logic [31:0] l_wdata;
    logic l_wr;
    logic l_rd;
    logic rd_wait;
    logic [31:0] result;
    logic done;
    logic refused;
    logic [3:0] key_mask;
    logic ptr_saved;
    logic ptr_restored;
    logic [6:0] sbox_rd_cnt;
    logic [6:0] sbox_wr_cnt;
    logic go_wr;
    logic go_rd;
    logic ok_wr;
    logic [1:0] kn;
    logic is_sbox;
    logic is_key;

    always_comb begin
        go_wr = sw_wr && sw_addr == HOFF_WRITE;
        go_rd = sw_wr && sw_addr == HOFF_READ;
        kn = target[1:0] - OFF_KEY_LOW[1:0];
        is_sbox = target[11:6] == OFF_SBOX_BASE[11:6];
        is_key = target >= OFF_KEY_LOW && target <= OFF_KEY_LOW + 12'h003;
        ok_wr = 1'b1;
        if (target == OFF_KEY_LEN) begin
            ok_wr = key_mask[0]; // [RULE_03]
        end else if (is_key) begin
            ok_wr = (kn == 2'h0) || key_mask[kn - 2'h1]; // [RULE_05]
        end
    end

    // link requests
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            l_addr <= 12'h000;
            l_wdata <= 32'h0000_0000;
            l_wr <= 1'b0;
            l_rd <= 1'b0;
            rd_wait <= 1'b0;
        end else begin
            l_wr <= go_wr && ok_wr;
            l_rd <= go_rd;
            rd_wait <= l_rd;
            if (go_wr || go_rd) begin
                l_addr <= target;
                l_wdata <= sw_wdata;
            end
        end
    end

    // software-side registers and bookkeeping
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            target <= 12'h000;
            result <= 32'h0000_0000;
            done <= 1'b0;
            refused <= 1'b0;
            key_mask <= 4'h0;
            ptr_saved <= 1'b0;
            ptr_restored <= 1'b0;
            sbox_rd_cnt <= 7'h00;
            sbox_wr_cnt <= 7'h00;
        end else begin
            if (sw_wr && sw_addr == HOFF_TARGET) begin
                target <= sw_wdata[11:0];
            end
            if (go_wr) begin
                refused <= !ok_wr;
                if (ok_wr && target == OFF_KEY_LEN) begin
                    key_mask <= 4'h0;
                end else if (ok_wr && is_key) begin
                    key_mask[kn] <= 1'b1;
                end
                if (ok_wr && target == OFF_POINTERS) begin
                    ptr_restored <= ptr_saved; // [RULE_13]
                end
                if (ok_wr && is_sbox && sbox_wr_cnt[6] == 1'b0) begin
                    sbox_wr_cnt <= sbox_wr_cnt + 7'h01; // [RULE_15]
                end
            end
            if (go_rd) begin
                refused <= 1'b0;
                if (target == OFF_POINTERS) begin
                    ptr_saved <= 1'b1; // [RULE_13]
                    ptr_restored <= 1'b0;
                    sbox_wr_cnt <= 7'h00;
                end
                if (is_sbox && sbox_rd_cnt[6] == 1'b0) begin
                    sbox_rd_cnt <= sbox_rd_cnt + 7'h01; // [RULE_15]
                end
            end
            if (go_wr || go_rd) begin
                done <= 1'b0;
            end else if (rd_wait || l_wr) begin
                done <= 1'b1;
            end
            if (rd_wait) begin
                result <= link.rdata;
            end
        end
    end

    // software read data
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            sw_rdata <= 32'h0000_0000;
        end else if (sw_rd) begin
            sw_rdata <= 32'h0000_0000;
            if (sw_addr == HOFF_TARGET) begin
                sw_rdata[11:0] <= target;
            end else if (sw_addr == HOFF_RESULT) begin
                sw_rdata <= result;
            end else if (sw_addr == HOFF_STATUS) begin
                sw_rdata[HST_DONE] <= done;
                sw_rdata[HST_REFUSED] <= refused;
                sw_rdata[HST_PTR_SAVED] <= ptr_saved;
                sw_rdata[HST_SBOX_SAVED] <= sbox_rd_cnt[6];
                sw_rdata[HST_PTR_RESTORED] <= ptr_restored;
                sw_rdata[HST_SBOX_RESTORED] <= sbox_wr_cnt[6];
            end
        end
    end

    assign link.addr = l_addr;
    assign link.wdata = l_wdata;
    assign link.wr = l_wr;
    assign link.rd = l_rd;
endmodule

// >>> verif/stream_cipher_assertions.sv
// Purpose: link protocol and register read checks between controller and cipher unit
// Assumes: one clock, srst synchronous active high
// Notes: instantiated beside the link interface
`timescale 1ns/1ps
module stream_cipher_assertions
    import stream_cipher_pkg::*;
(
    input wire logic sys_clk,
    input wire logic srst,
    input wire logic [11:0] addr,
    input wire logic [31:0] wdata,
    input wire logic wr,
    input wire logic rd,
    input wire logic [31:0] rdata
);
    logic [7:0] since_start;
    default clocking @(posedge sys_clk); endclocking
    default disable iff (srst);
    // cycles since reset, software reset or key length write
    always_ff @(posedge sys_clk) begin
        if (srst || (wr && addr == OFF_KEY_LEN)) begin
            since_start <= 8'h00;
        end else if (wr && addr == OFF_CONTROL && wdata[CTL_SOFT_RESET_BIT]) begin
            since_start <= 8'h00;
        end else if (since_start != 8'hFF) begin
            since_start <= since_start + 8'h01;
        end
    end
    a_strobes_apart: assert property (!(wr && rd))
        else $error("write and read strobes together");
    a_write_single: assert property (wr |=> !wr)
        else $error("write strobe longer than one cycle");
    a_read_single: assert property (rd |=> !rd)
        else $error("read strobe longer than one cycle");
    a_read_held: assert property (!rd |=> $stable(rdata))
        else $error("read data changed without a read");
    a_unmapped_zero: assert property (rd && ((addr > OFF_POINTERS && addr < OFF_SBOX_BASE)
        || addr > 12'h47F) |=> rdata == 32'h0)
        else $error("unmapped read not zero");
    a_status_clean: assert property (rd && addr == OFF_STATUS
        |=> rdata[31:7] == 25'h0 && !rdata[1])
        else $error("status reserved bits set");
    a_pointer_width: assert property (rd && addr == OFF_POINTERS
        |=> rdata[31:24] == 8'h00)
        else $error("pointer register wider than 24 bits");
    a_busy_at_start: assert property (rd && addr == OFF_STATUS && since_start < 8'h3C
        |=> rdata[ST_BUSY])
        else $error("not busy soon after start");
endmodule

// >>> verif/test_stream_cipher_host_registers.sv
// Purpose: drives the controller software port and judges the cipher unit behind it
// Assumes: controller answers as the hand-over timing gives
// Notes: keystream reference model kept in the bench
`timescale 1ns/1ps
module test_stream_cipher_host_registers;
    import stream_cipher_pkg::*;
    logic sys_clk = 1'b0;
    logic srst = 1'b1;
    logic [3:0] sw_addr = 4'h0;
    logic [31:0] sw_wdata = 32'h0;
    logic sw_wr = 1'b0;
    logic sw_rd = 1'b0;
    logic [31:0] sw_rdata;
    int n_errors = 0;
    int comparisons = 0;
    int cycles = 0;
    logic [7:0] s [256];
    logic [7:0] mi;
    logic [7:0] mj;
    stream_cipher_link stream_cipher_link_inst ();
    stream_cipher_unit stream_cipher_unit_inst (.sys_clk(sys_clk), .srst(srst),
        .link(stream_cipher_link_inst));
    stream_cipher_host stream_cipher_host_inst (.sys_clk(sys_clk), .srst(srst),
        .sw_addr(sw_addr), .sw_wdata(sw_wdata), .sw_wr(sw_wr), .sw_rd(sw_rd),
        .sw_rdata(sw_rdata), .link(stream_cipher_link_inst));
    stream_cipher_assertions stream_cipher_assertions_inst (.sys_clk(sys_clk), .srst(srst),
        .addr(stream_cipher_link_inst.addr), .wdata(stream_cipher_link_inst.wdata),
        .wr(stream_cipher_link_inst.wr), .rd(stream_cipher_link_inst.rd),
        .rdata(stream_cipher_link_inst.rdata));
    always #25 sys_clk = ~sys_clk;
    always @(posedge sys_clk) begin
        cycles++;
        if (cycles == 40000) begin
            n_errors++;
            finish_test();
        end
    end
    task automatic finish_test();
        $display("comparisons %0d n_errors %0d", comparisons, n_errors);
        if (n_errors == 0 && comparisons > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            n_errors++;
            $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic sw_write(input logic [3:0] a, input logic [31:0] d);
        @(posedge sys_clk);
        sw_wr <= 1'b1;
        sw_addr <= a;
        sw_wdata <= d;
        @(posedge sys_clk);
        sw_wr <= 1'b0;
    endtask
    task automatic sw_read(input logic [3:0] a, output logic [31:0] d);
        @(posedge sys_clk);
        sw_rd <= 1'b1;
        sw_addr <= a;
        @(posedge sys_clk);
        sw_rd <= 1'b0;
        #1 d = sw_rdata;
    endtask
    task automatic dev_wr(input logic [11:0] a, input logic [31:0] d);
        sw_write(HOFF_TARGET, {20'h0, a});
        sw_write(HOFF_WRITE, d);
        repeat (3) @(posedge sys_clk);
    endtask
    task automatic dev_rd(input logic [11:0] a, output logic [31:0] d);
        sw_write(HOFF_TARGET, {20'h0, a});
        sw_write(HOFF_READ, 32'h0);
        repeat (3) @(posedge sys_clk);
        sw_read(HOFF_RESULT, d);
    endtask
    task automatic wait_idle();
        logic [31:0] st;
        for (int k = 0; k < 100; k++) begin
            dev_rd(OFF_STATUS, st);
            if (st[ST_BUSY] === 1'b0) break;
        end
    endtask
    task automatic swap(input logic [7:0] a, input logic [7:0] b);
        logic [7:0] t;
        t = s[a];
        s[a] = s[b];
        s[b] = t;
    endtask
    task automatic ks(output logic [7:0] k);
        logic [7:0] x;
        mi = mi + 8'h01;
        mj = mj + s[mi];
        swap(mi, mj);
        x = s[mi] + s[mj];
        k = s[x];
    endtask
    function automatic logic [31:0] sword(input int w);
        return {s[4*w+3], s[4*w+2], s[4*w+1], s[4*w]};
    endfunction
    task automatic t_init();
        logic [31:0] d;
        wait_idle();
        dev_rd(OFF_STATUS, d);
        check(d, 32'h0000_0044);
        dev_rd(OFF_SBOX_BASE, d);
        check(d, 32'h0302_0100);
        dev_rd(OFF_SBOX_BASE + 12'h03F, d);
        check(d, 32'hFFFE_FDFC);
        dev_rd(12'h420, d);
        check(d, 32'h0);
    endtask
    task automatic t_key();
        logic [31:0] d;
        logic [7:0] j;
        dev_wr(OFF_KEY_LEN, 32'h4);
        sw_read(HOFF_STATUS, d);
        check(32'(d[HST_REFUSED]), 32'h1);
        dev_wr(OFF_KEY_LOW, 32'h4433_2211);
        sw_read(HOFF_STATUS, d);
        check(32'(d[1:0]), 32'h1);
        dev_wr(OFF_KEY_LOW + 12'h002, 32'h0000_0077);
        sw_read(HOFF_STATUS, d);
        check(32'(d[HST_REFUSED]), 32'h1);
        dev_wr(OFF_KEY_LOW + 12'h001, 32'h0000_0055);
        dev_wr(OFF_KEY_LEN, 32'h4);
        dev_wr(OFF_SBOX_BASE, 32'hDEAD_BEEF);
        dev_rd(OFF_STATUS, d);
        check(32'(d[ST_BUSY]), 32'h1);
        j = 8'h00;
        for (int i = 0; i < 256; i++) s[i] = i[7:0];
        for (int i = 0; i < 256; i++) begin
            j = j + s[i] + 8'(40'h55_4433_2211 >> (8 * (i % 5)));
            swap(i[7:0], j);
        end
        mi = 8'h00;
        mj = 8'h00;
        wait_idle();
        dev_rd(OFF_STATUS, d);
        check(d, 32'h0000_0048);
        for (int w = 0; w < 64; w++) begin
            dev_rd(OFF_SBOX_BASE + 12'(w), d);
            check(d, sword(w));
        end
    endtask
    task automatic t_message(input logic [31:0] m, input int n, output logic [31:0] e);
        logic [7:0] k;
        e = m;
        for (int b = 0; b < n; b++) begin
            ks(k);
            e[31-8*b -: 8] = m[31-8*b -: 8] ^ k;
        end
        dev_wr(OFF_MESSAGE, m);
        wait_idle();
    endtask
    task automatic t_stream();
        logic [31:0] d;
        logic [31:0] e;
        logic [31:0] p;
        logic [31:0] saved [64];
        t_message(32'hA1B2_C3D4, 4, e);
        dev_rd(OFF_STATUS, d);
        check(d, 32'h0000_0050);
        dev_rd(OFF_OUTPUT, d);
        check(d, e);
        dev_rd(OFF_POINTERS, p);
        check(p, {8'h00, mi, mj});
        for (int w = 0; w < 64; w++) begin
            dev_rd(OFF_SBOX_BASE + 12'(w), saved[w]);
            check(saved[w], sword(w));
        end
        dev_wr(OFF_POINTERS, 32'h0000_1234);
        dev_rd(OFF_POINTERS, d);
        check(d, 32'h0000_1234);
        dev_wr(OFF_SBOX_BASE + 12'h001, 32'h5A5A_5A5A);
        dev_rd(OFF_SBOX_BASE + 12'h001, d);
        check(d, 32'h5A5A_5A5A);
        dev_wr(OFF_POINTERS, p);
        for (int w = 0; w < 64; w++) dev_wr(OFF_SBOX_BASE + 12'(w), saved[w]);
        sw_read(HOFF_STATUS, d);
        check(32'(d[5:2]), 32'hF);
        dev_wr(OFF_BYTE_COUNT, 32'h5);
        t_message(32'h1122_3344, 2, e);
        dev_rd(OFF_STATUS, d);
        check(32'(d[ST_FULL_DONE]), 32'h1);
        dev_rd(OFF_OUTPUT, d);
        check(d, e);
        dev_rd(OFF_STATUS, d);
        check(32'(d[ST_FULL_DONE]), 32'h0);
        dev_rd(OFF_SBOX_BASE, d);
        check(d, 32'h0302_0100);
    endtask
    task automatic t_soft_reset();
        logic [31:0] d;
        dev_wr(OFF_CONTROL, 32'h0000_0002);
        dev_rd(OFF_STATUS, d);
        check(32'(d[ST_BUSY]), 32'h1);
        wait_idle();
        dev_rd(OFF_STATUS, d);
        check(d, 32'h0000_0044);
    endtask
    initial begin
        repeat (6) @(posedge sys_clk);
        srst <= 1'b0;
        t_init();
        t_key();
        t_stream();
        t_soft_reset();
        finish_test();
    end
endmodule
